/* File: charger_interrupt_mask_unit.sv */
// Top: interrupt enable byte, pending request and step-up regulator control
`timescale 1ns/1ps
module charger_interrupt_mask_unit (
  // Clock and reset
  input  wire logic                     REF_CLK,
  input  wire logic                     RST,
  // Register port
  input  wire irq_mask_pkg::reg_req_t   REG_REQ,
  output logic [7:0]                    REG_RDATA,
  output logic                          REG_RVALID,
  // Analog status and configuration
  input  wire irq_mask_pkg::status_t    STATUS_IN,
  input  wire logic                     ID_AUTOSTART_LOCKOUT,
  // Outputs
  output logic                          IRQ_N,
  output logic                          BOOST_ENABLE,
  output logic [7:0]                    MASK_OUT
);
  // Filtered status and its copy one cycle older
  irq_mask_pkg::status_t st;
  irq_mask_pkg::status_t st_prev_q;
  logic                  primed_q;
  // Mask byte, read answer and pending request
  logic [7:0]            mask_q;
  logic [7:0]            mask_d;
  logic [7:0]            rdata_d;
  logic                  pending_q;
  logic                  pending_d;
  // Register decode
  logic                  addr_hit;
  logic                  mask_wr;
  logic                  mask_rd;
  // Group enables from the mask byte
  logic                  en_charger;
  logic                  en_fault;
  logic                  en_supply;
  logic                  en_host;
  logic                  en_cap;
  logic                  en_brownout;
  // Any flag of a group moved since the last cycle
  logic                  mv_charger;
  logic                  mv_fault;
  logic                  mv_supply;
  logic                  mv_host;
  logic                  mv_cap;
  logic                  mv_brownout;
  // Enabled changes
  logic                  ev_charger;
  logic                  ev_fault;
  logic                  ev_supply;
  logic                  ev_host;
  logic                  ev_cap;
  logic                  ev_brownout;
  logic                  event_any;
  // Step-up regulator control
  logic                  lockout;
  logic                  input_powered;
  logic                  auto_start;
  logic                  boost_d;

  // Groups are padded to four flags so one compare serves them all
  function automatic logic moved(input logic [3:0] cur, input logic [3:0] old);
    moved = |(cur ^ old);
  endfunction

  // Status pins come from the analog side, outside this clock
  status_sync #(
    .W (irq_mask_pkg::STATUS_W)
  ) u_sync (
    .clk       (REF_CLK),
    .rst       (RST),
    .async_in  (STATUS_IN),
    .clean_out (st)
  );

  // Lockout pin is filtered like the status pins
  status_sync #(
    .W (1)
  ) u_lock_sync (
    .clk       (REF_CLK),
    .rst       (RST),
    .async_in  (ID_AUTOSTART_LOCKOUT),
    .clean_out (lockout)
  );

  assign addr_hit = (REG_REQ.addr == irq_mask_pkg::MASK_REG_ADDR);
  assign mask_wr  = REG_REQ.wr && addr_hit;
  assign mask_rd  = REG_REQ.rd && addr_hit;
  // Every bit is stored as written, none is reserved
  assign mask_d   = mask_wr ? REG_REQ.wdata : mask_q;
  // Unmapped reads answer zero rather than stale data
  assign rdata_d  = mask_rd ? mask_q : 8'h00;

  assign en_charger  = mask_q[irq_mask_pkg::CHARGER_EN_BIT];
  assign en_fault    = mask_q[irq_mask_pkg::FAULT_EN_BIT];
  assign en_supply   = mask_q[irq_mask_pkg::SUPPLY_EN_BIT];
  assign en_host     = mask_q[irq_mask_pkg::HOST_EN_BIT];
  assign en_cap      = mask_q[irq_mask_pkg::CAP_EN_BIT];
  assign en_brownout = mask_q[irq_mask_pkg::BROWNOUT_EN_BIT];

  assign mv_charger  = moved({1'h0, st.charger_status},
                             {1'h0, st_prev_q.charger_status});
  assign mv_fault    = moved({st.overvoltage_flag, st.bad_cell_flag,
                              st.boost_fault_flag, st.thermistor_overheat_flag},
                             {st_prev_q.overvoltage_flag, st_prev_q.bad_cell_flag,
                              st_prev_q.boost_fault_flag,
                              st_prev_q.thermistor_overheat_flag});
  assign mv_supply   = moved({1'h0, st.usb_input_good, st.adapter_input_good,
                              st.external_supply_good},
                             {1'h0, st_prev_q.usb_input_good,
                              st_prev_q.adapter_input_good,
                              st_prev_q.external_supply_good});
  assign mv_host     = moved({2'h0, st.boost_running_flag, st.id_pin_detected},
                             {2'h0, st_prev_q.boost_running_flag,
                              st_prev_q.id_pin_detected});
  assign mv_cap      = moved({3'h0, st.input_current_capped},
                             {3'h0, st_prev_q.input_current_capped});
  assign mv_brownout = moved({3'h0, st.brownout_limit_flag},
                             {3'h0, st_prev_q.brownout_limit_flag});

  assign ev_charger  = en_charger && mv_charger;
  assign ev_fault    = en_fault && mv_fault;
  assign ev_supply   = en_supply && mv_supply;
  assign ev_host     = en_host && mv_host;
  assign ev_cap      = en_cap && mv_cap;
  assign ev_brownout = en_brownout && mv_brownout;

  // No events until the first filtered sample has been taken
  assign event_any = primed_q && (ev_charger || ev_fault || ev_supply
                     || ev_host || ev_cap || ev_brownout);
  // Set wins over the clearing write so a coincident event is not lost
  assign pending_d = event_any ? 1'h1 : (mask_wr ? 1'h0 : pending_q);

  assign input_powered = st.usb_input_good || st.adapter_input_good;
  assign auto_start    = !lockout && st.id_pin_detected;
  assign boost_d       = !input_powered
                         && (mask_q[irq_mask_pkg::BOOST_REQ_BIT] || auto_start);

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_prev_q <= '0;
    end else begin
      st_prev_q <= st;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      primed_q <= 1'h0;
    end else begin
      primed_q <= 1'h1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pending_q <= 1'h0;
    end else begin
      pending_q <= pending_d;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      mask_q <= irq_mask_pkg::MASK_REG_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      REG_RVALID <= 1'h0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 8'h00;
    end else begin
      REG_RDATA <= rdata_d;
    end
  end

  // Taken from the next pending value so the pin follows without extra delay
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      IRQ_N <= 1'h1;
    end else begin
      IRQ_N <= !pending_d;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      BOOST_ENABLE <= 1'h0;
    end else begin
      BOOST_ENABLE <= boost_d;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      MASK_OUT <= irq_mask_pkg::MASK_REG_RESET;
    end else begin
      MASK_OUT <= mask_d;
    end
  end
endmodule

/* File: irq_mask_pkg.sv */
// Package: register map, field positions and types of the charger interrupt mask unit
package irq_mask_pkg;
  localparam logic [7:0] MASK_REG_ADDR   = 8'h06;
  localparam logic [7:0] MASK_REG_RESET  = 8'h00;
  localparam int         CHARGER_EN_BIT  = 7;
  localparam int         FAULT_EN_BIT    = 6;
  localparam int         SUPPLY_EN_BIT   = 5;
  localparam int         HOST_EN_BIT     = 4;
  localparam int         CAP_EN_BIT      = 3;
  localparam int         BROWNOUT_EN_BIT = 2;
  localparam int         BOOST_REQ_BIT   = 1;
  localparam int         SYNC_STAGES     = 3;

  // Analog status inputs, grouped by interrupt source
  typedef struct packed {
    logic [2:0] charger_status;
    logic       overvoltage_flag;
    logic       bad_cell_flag;
    logic       boost_fault_flag;
    logic       thermistor_overheat_flag;
    logic       usb_input_good;
    logic       adapter_input_good;
    logic       external_supply_good;
    logic       boost_running_flag;
    logic       id_pin_detected;
    logic       input_current_capped;
    logic       brownout_limit_flag;
  } status_t;

  localparam int STATUS_W = $bits(status_t);

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
endpackage

/* File: status_sync.sv */
// Three-stage synchroniser with agreement filter for the analog status inputs
`timescale 1ns/1ps
module status_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] clean_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_d;

  // Only bits on which stages two and three agree may move
  assign clean_d = (s2_q & s3_q) | (clean_out & (s2_q | s3_q));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q      <= '0;
      s2_q      <= '0;
      s3_q      <= '0;
      clean_out <= '0;
    end else begin
      s1_q      <= async_in;
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      clean_out <= clean_d;
    end
  end
endmodule

/* File: charger_interrupt_mask_unit_sva.sv */
// Checker: port timing of the charger interrupt mask unit
`timescale 1ns/1ps
module charger_interrupt_mask_unit_sva (
  input wire logic                   REF_CLK,
  input wire logic                   RST,
  input wire irq_mask_pkg::reg_req_t REG_REQ,
  input wire logic [7:0]             REG_RDATA,
  input wire logic                   REG_RVALID,
  input wire irq_mask_pkg::status_t  STATUS_IN,
  input wire logic                   ID_AUTOSTART_LOCKOUT,
  input wire logic                   IRQ_N,
  input wire logic                   BOOST_ENABLE,
  input wire logic [7:0]             MASK_OUT
);
  wire logic wr06 = REG_REQ.wr && REG_REQ.addr == irq_mask_pkg::MASK_REG_ADDR;
  wire logic ext  = STATUS_IN.usb_input_good || STATUS_IN.adapter_input_good;
  wire logic auto_ok  = !ext && STATUS_IN.id_pin_detected && !ID_AUTOSTART_LOCKOUT;
  wire logic lock_off = ID_AUTOSTART_LOCKOUT && !MASK_OUT[irq_mask_pkg::BOOST_REQ_BIT];
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Long enough for the input filter to settle
  sequence s_quiet;
    $stable(STATUS_IN)[*7];
  endsequence
  chk_rvalid_pulse: assert property (REG_REQ.rd |=> REG_RVALID)
    else $error("read answer missing");
  chk_read_data: assert property (REG_REQ.rd |=> REG_RDATA ==
    ($past(REG_REQ.addr) == irq_mask_pkg::MASK_REG_ADDR ? $past(MASK_OUT) : 8'h00))
    else $error("read data wrong");
  chk_mask_store: assert property (wr06 |=> MASK_OUT == $past(REG_REQ.wdata))
    else $error("mask not stored");
  chk_mask_hold: assert property (!wr06 |=> $stable(MASK_OUT))
    else $error("mask changed without write");
  chk_irq_sticky: assert property (!IRQ_N && !wr06 |=> !IRQ_N)
    else $error("interrupt dropped early");
  chk_irq_clear: assert property (s_quiet ##0 wr06 |=> IRQ_N)
    else $error("write did not clear interrupt");
  chk_irq_quiet: assert property (s_quiet ##0 IRQ_N |=> IRQ_N)
    else $error("interrupt without change");
  chk_no_enable: assert property ((MASK_OUT[7:2] == 6'h00)[*8] |-> !$fell(IRQ_N))
    else $error("interrupt while all groups off");
  chk_boost_block: assert property (ext[*8] |-> !BOOST_ENABLE)
    else $error("boost with input powered");
  chk_boost_manual: assert property ((MASK_OUT[1] && !ext)[*8] |-> BOOST_ENABLE)
    else $error("manual boost missing");
  chk_boost_auto: assert property (auto_ok[*8] |-> BOOST_ENABLE)
    else $error("automatic boost missing");
  chk_lockout_hold: assert property (lock_off[*8] |-> !BOOST_ENABLE)
    else $error("boost despite lockout");
endmodule

bind charger_interrupt_mask_unit charger_interrupt_mask_unit_sva sva (.REF_CLK, .RST, .REG_REQ,
  .REG_RDATA, .REG_RVALID, .STATUS_IN, .ID_AUTOSTART_LOCKOUT, .IRQ_N, .BOOST_ENABLE,
  .MASK_OUT);

/* File: reg_host.sv */
// Register host model driving the unit's register port
`timescale 1ns/1ps
module reg_host (
  input  wire logic              REF_CLK,
  output irq_mask_pkg::reg_req_t REQ,
  input  wire logic [7:0]        RDATA,
  input  wire logic              RVALID
);
  initial REQ = '0;
  // One-cycle request; answer taken the cycle after
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge REF_CLK) #1 REQ = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge REF_CLK) #1 REQ = '0;
    q = (w | RVALID) ? RDATA : 8'hXX;
  endtask
endmodule

/* File: charger_interrupt_mask_unit_bench.sv */
// Self-checking bench for the charger interrupt mask unit
`timescale 1ns/1ps
module charger_interrupt_mask_unit_bench;
  logic                   clk, rst, lock, irq_n, boost;
  irq_mask_pkg::reg_req_t req;
  irq_mask_pkg::status_t  status;
  logic [7:0]             rdata, mask, q;
  logic                   rvalid;
  int                     n_errors = 0, checks = 0, cyc = 0, g;
  reg_host host (.REF_CLK(clk), .REQ(req), .RDATA(rdata), .RVALID(rvalid));
  charger_interrupt_mask_unit uut (.REF_CLK(clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .STATUS_IN(status), .ID_AUTOSTART_LOCKOUT(lock), .IRQ_N(irq_n),
    .BOOST_ENABLE(boost), .MASK_OUT(mask));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string s, input logic [7:0] e, v);
    checks++;
    if (v !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic conclude;
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    rst = 1'b1;
    lock = 1'b0;
    status = '0;
    tick(2);
    rst = 1'b0;
    host.xfer(1'b0, 8'h06, 8'h00, q);
    chk("reset mask", irq_mask_pkg::MASK_REG_RESET, q);
    host.xfer(1'b1, 8'h06, 8'hFF, q);
    host.xfer(1'b1, 8'h07, 8'h00, q);
    host.xfer(1'b0, 8'h07, 8'h00, q);
    chk("unmapped read", 8'h00, q);
    host.xfer(1'b0, 8'h06, 8'h00, q);
    chk("readback", 8'hFF, q);
    // Every flag, first with its group off, then on
    for (int i = 0; i < 14; i++) begin
      g = i > 10 ? 7 : i > 6 ? 6 : i > 3 ? 5 : i > 1 ? 4 : i + 2;
      host.xfer(1'b1, 8'h06, 8'hFC ^ (8'h01 << g), q);
      status[i] = ~status[i];
      tick(8);
      chk("masked event", 8'h01, {7'h00, irq_n});
      host.xfer(1'b1, 8'h06, 8'h01 << g, q);
      status[i] = ~status[i];
      tick(8);
      chk("enabled event", 8'h00, {7'h00, irq_n});
      host.xfer(1'b1, 8'h06, 8'h00, q);
      chk("cleared", 8'h01, {7'h00, irq_n});
    end
    for (int k = 0; k < 32; k++) begin
      host.xfer(1'b1, 8'h06, {6'h00, k[0], 1'b0}, q);
      {status.usb_input_good, status.adapter_input_good, status.id_pin_detected, lock} = k[4:1];
      tick(10);
      chk("boost", {7'h00, !(k[4] | k[3]) & (k[0] | (!k[1] & k[2]))}, {7'h00, boost});
    end
    conclude();
  end
endmodule
